// [xra_top.sv]
// management register bank: indirect extended access window plus link drop and summary status
`timescale 1ns/1ps
module xra_top (
	input  wire logic                        clock_in,
	input  wire logic                        rst_in,
	input  wire xra_pkg::xra_req_t           req_in,
	input  wire xra_pkg::xra_drop_t          drop_in,
	input  wire logic                        rx_error_in,
	input  wire logic                        auto_crossover_enable_in,
	input  wire logic                        forced_crossover_in,
	input  wire logic                        swap_algorithm_in,
	output logic      [15:0]                 rd_data_out,
	output logic                             rd_valid_out,
	output logic                             link_drop_out,
	output logic      [15:0]                 pointer_out
);
	import xra_pkg::*;

	// ==========================================================
	// helpers
	function automatic logic is_extended(input logic [15:0] addr);
		return (addr >= EXT_FIRST) && (addr <= EXT_LAST); // R15
	endfunction

	logic [1:0]          func;
	logic [4:0]          target_device_field;
	logic [15:0]         pointer;
	logic [15:0]         next_pointer;
	logic                window_on;
	logic                window_rd;
	logic                window_wr;
	logic                data_mode;
	logic                bump;
	logic                ext_we;
	logic [15:0]         ext_rdata;
	logic [15:0]         window_rdata;
	logic [CAUSE_W-1:0]  cause;
	logic                rx_err_latch;
	logic                crossover;
	logic                status_drop;
	logic [15:0]         next_rdata;

	// ==========================================================
	// access control register
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			func                <= CTRL_RESET[FUNC_HI:FUNC_LO];
			target_device_field <= CTRL_RESET[DEV_HI:DEV_LO];
		end else if (req_in.wr && req_in.addr == ADDR_EXT_CTRL) begin
			func                <= req_in.wdata[FUNC_HI:FUNC_LO];
			target_device_field <= req_in.wdata[DEV_HI:DEV_LO]; // R05
		end
	end

	// ==========================================================
	// window decode; the controller is expected to set the device field first
	assign window_on = (target_device_field == DEV_EXTENDED); // R06 R08
	assign window_rd = req_in.rd && req_in.addr == ADDR_WINDOW && window_on; // R07
	assign window_wr = req_in.wr && req_in.addr == ADDR_WINDOW && window_on; // R07
	assign data_mode = (func != FUNC_ADDRESS); // R09

	always_comb begin
		case (func)
			FUNC_ADDRESS:  bump = 1'b0; // R01
			FUNC_DATA:     bump = 1'b0; // R02
			FUNC_DATA_INC: bump = window_rd | window_wr; // R03
			FUNC_DATA_WR:  bump = window_wr; // R04
			default:       bump = 1'b0;
		endcase
	end

	// ==========================================================
	// extended address pointer; plain 16-bit add wraps to zero
	always_comb begin
		next_pointer = pointer;
		if (window_wr && !data_mode) begin
			next_pointer = req_in.wdata; // R01 R09
		end else if (bump) begin
			next_pointer = pointer + 16'h0001; // R03 R04 R17
		end
	end

	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			pointer <= POINTER_RESET; // R17
		end else begin
			pointer <= next_pointer;
		end
	end

	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			pointer_out <= POINTER_RESET;
		end else begin
			pointer_out <= next_pointer;
		end
	end

	// writes outside the extended range are dropped, reads there return zero
	assign ext_we = window_wr && data_mode && is_extended(pointer); // R02 R15

	xra_ext_regs u_ext_regs (
		.clock_in  (clock_in),
		.rst_in    (rst_in),
		.we_in     (ext_we),
		.index_in  (pointer[EXT_INDEX_W-1:0]),
		.wdata_in  (req_in.wdata),
		.rdata_out (ext_rdata)
	);

	always_comb begin
		if (!data_mode) begin
			window_rdata = pointer; // R09
		end else if (is_extended(pointer)) begin
			window_rdata = ext_rdata; // R02 R09
		end else begin
			window_rdata = 16'h0000;
		end
	end

	// ==========================================================
	// status block; reads of the cause and error count registers clear their latches
	xra_status u_status (
		.clock_in                 (clock_in),
		.rst_in                   (rst_in),
		.drop_in                  (drop_in),
		.cause_clear_in           (req_in.rd && req_in.addr == ADDR_LINK_DROP),
		.rx_error_in              (rx_error_in),
		.rx_err_clear_in          (req_in.rd && req_in.addr == ADDR_RX_ERR_COUNT), // R14
		.auto_crossover_enable_in (auto_crossover_enable_in),
		.forced_crossover_in      (forced_crossover_in),
		.swap_algorithm_in        (swap_algorithm_in),
		.cause_out                (cause),
		.rx_err_latch_out         (rx_err_latch),
		.crossover_out            (crossover),
		.link_drop_out            (status_drop)
	);

	assign link_drop_out = status_drop;

	// ==========================================================
	// read mux; unmapped addresses read zero
	always_comb begin
		next_rdata = 16'h0000;
		case (req_in.addr)
			ADDR_EXT_CTRL: begin
				next_rdata[FUNC_HI:FUNC_LO] = func;
				next_rdata[DEV_HI:DEV_LO]   = target_device_field; // R05
			end
			ADDR_WINDOW: begin
				next_rdata = window_on ? window_rdata : 16'h0000; // R07
			end
			ADDR_LINK_DROP: begin
				next_rdata[CAUSE_LO+CAUSE_W-1:CAUSE_LO] = cause; // R10 R11
			end
			ADDR_SUMMARY: begin
				next_rdata[SUM_XOVER_BIT] = crossover; // R12
				next_rdata[SUM_RXERR_BIT] = rx_err_latch; // R14
			end
			default: begin
				next_rdata = 16'h0000;
			end
		endcase
	end

	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			rd_data_out  <= 16'h0000;
			rd_valid_out <= 1'b0;
		end else begin
			rd_valid_out <= req_in.rd;
			if (req_in.rd) begin
				rd_data_out <= next_rdata;
			end
		end
	end

endmodule // xra_top

// [xra_pkg.sv]
// constants, field layouts and carrier types for the extended register indirect access block
// Functional notes
// R01 - Function code 00 makes window accesses act on the extended address pointer.
// R02 - Function code 01 reaches the pointed extended register and leaves the pointer alone.
// R03 - Function code 10 reaches the pointed extended register and bumps the pointer after every read and write.
// R04 - Function code 11 reaches the pointed extended register and bumps the pointer after writes only.
// R05 - Access control bits 13:5 ignore writes and read as zero.
// R06 - Window accesses are served only while the target device field holds 11111.
// R07 - Window accesses with any other target device value change neither pointer nor extended registers.
// R08 - The management controller loads 0x1F into the target device field before using the window.
// R09 - The window reads and writes the pointer under code 00 and the pointed register's data otherwise.
// R10 - Each link drop cause bit latches one when its enabled criterion drops the link.
// R11 - Cause bits are: 4 descrambler sync loss, 3 receive errors, 2 code errors, 1 low SNR, 0 energy loss.
// R12 - Summary status bit 14 is one when the pairs are swapped and zero when normal.
// R13 - Bit 14 follows the swap algorithm when crossover is enabled and not forced; enable and force decide it.
// R14 - Summary status bit 13 latches on a receive error and clears on a read of register 0x0015.
// R15 - The window reaches the extended registers above 0x001F, which have no direct address.
// R16 - The link drop decision is the OR of the individually enabled criteria.
// R17 - The extended pointer resets to zero and wraps to zero after incrementing from its maximum.
package xra_pkg;

	// ==========================================================
	// register addresses
	localparam logic [4:0]  ADDR_EXT_CTRL      = 5'h0d;
	localparam logic [4:0]  ADDR_WINDOW        = 5'h0e;
	localparam logic [4:0]  ADDR_LINK_DROP     = 5'h0f;
	localparam logic [4:0]  ADDR_SUMMARY       = 5'h10;
	localparam logic [4:0]  ADDR_RX_ERR_COUNT  = 5'h15;

	// ==========================================================
	// access control fields
	localparam int          FUNC_HI            = 15;
	localparam int          FUNC_LO            = 14;
	localparam int          DEV_HI             = 4;
	localparam int          DEV_LO             = 0;
	localparam logic [4:0]  DEV_EXTENDED       = 5'h1f;
	localparam logic [15:0] CTRL_RESET         = 16'h0000;
	localparam logic [15:0] POINTER_RESET      = 16'h0000;

	// ==========================================================
	// status fields
	localparam int          CAUSE_LO           = 4;
	localparam int          CAUSE_W            = 5;
	localparam int          SUM_XOVER_BIT      = 14;
	localparam int          SUM_RXERR_BIT      = 13;
	localparam int          CAUSE_DESCRAMBLER  = 4;
	localparam int          CAUSE_RX_ERRORS    = 3;
	localparam int          CAUSE_CODE_ERRORS  = 2;
	localparam int          CAUSE_LOW_SNR      = 1;
	localparam int          CAUSE_ENERGY_LOSS  = 0;

	// ==========================================================
	// extended register storage
	localparam int          EXT_INDEX_W        = 8;
	localparam int          EXT_DEPTH          = 256;
	localparam logic [15:0] EXT_FIRST          = 16'h0020;
	localparam logic [15:0] EXT_LAST           = 16'h00ff;

	typedef enum logic [1:0] {
		FUNC_ADDRESS  = 2'b00,
		FUNC_DATA     = 2'b01,
		FUNC_DATA_INC = 2'b10,
		FUNC_DATA_WR  = 2'b11
	} xra_func_t;

	typedef struct packed {
		logic [4:0]  addr;
		logic        rd;
		logic        wr;
		logic [15:0] wdata;
	} xra_req_t;

	typedef struct packed {
		logic [CAUSE_W-1:0] trigger;
		logic [CAUSE_W-1:0] enable;
	} xra_drop_t;

endpackage

// [xra_ext_regs.sv]
// storage for the extended register set reached through the window
`timescale 1ns/1ps
module xra_ext_regs (
	input  wire logic                              clock_in,
	input  wire logic                              rst_in,
	input  wire logic                              we_in,
	input  wire logic [xra_pkg::EXT_INDEX_W-1:0]   index_in,
	input  wire logic [15:0]                       wdata_in,
	output logic      [15:0]                       rdata_out
);
	import xra_pkg::*;

	logic [15:0] mem [EXT_DEPTH];

	// ==========================================================
	// array with reset so every extended register reads zero after reset
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			for (int i = 0; i < EXT_DEPTH; i++) begin
				mem[i] <= 16'h0000;
			end
		end else if (we_in) begin
			mem[index_in] <= wdata_in;
		end
	end

	assign rdata_out = mem[index_in];

endmodule // xra_ext_regs

// [xra_status.sv]
// link drop cause latches, receive error latch and crossover status
`timescale 1ns/1ps
module xra_status (
	input  wire logic                            clock_in,
	input  wire logic                            rst_in,
	input  wire xra_pkg::xra_drop_t              drop_in,
	input  wire logic                            cause_clear_in,
	input  wire logic                            rx_error_in,
	input  wire logic                            rx_err_clear_in,
	input  wire logic                            auto_crossover_enable_in,
	input  wire logic                            forced_crossover_in,
	input  wire logic                            swap_algorithm_in,
	output logic      [xra_pkg::CAUSE_W-1:0]     cause_out,
	output logic                                 rx_err_latch_out,
	output logic                                 crossover_out,
	output logic                                 link_drop_out
);
	import xra_pkg::*;

	logic [CAUSE_W-1:0] fired;

	assign fired = drop_in.trigger & drop_in.enable;

	// ==========================================================
	// cause latches; a new drop in the clearing read cycle survives
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			cause_out <= '0;
		end else begin
			cause_out <= (cause_clear_in ? '0 : cause_out) | fired; // R10 R11
		end
	end

	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			link_drop_out <= 1'b0;
		end else begin
			link_drop_out <= |fired; // R16
		end
	end

	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			rx_err_latch_out <= 1'b0;
		end else begin
			rx_err_latch_out <= (rx_err_latch_out & ~rx_err_clear_in) | rx_error_in; // R14
		end
	end

	// ==========================================================
	// force wins over the algorithm; disabled and unforced means normal pairs
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			crossover_out <= 1'b0;
		end else if (forced_crossover_in) begin
			crossover_out <= 1'b1; // R12 R13
		end else begin
			crossover_out <= auto_crossover_enable_in & swap_algorithm_in; // R13
		end
	end

endmodule // xra_status

// [xra_top_monitor.sv]
// assertion checker for the extended register access bank
`timescale 1ns/1ps
module xra_top_monitor (
	input wire logic              clock_in,
	input wire logic              rst_in,
	input wire xra_pkg::xra_req_t req_in,
	input wire xra_pkg::xra_drop_t drop_in,
	input wire logic [15:0]       rd_data_out,
	input wire logic              rd_valid_out,
	input wire logic              link_drop_out,
	input wire logic [15:0]       pointer_out
);
	import xra_pkg::*;
	// ====================
	// shadow of the access control word, seen only through the request port
	logic [15:0] ctrl;
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) ctrl <= 16'h0000;
		else if (req_in.wr && req_in.addr == ADDR_EXT_CTRL) ctrl <= req_in.wdata;
	end
	wire logic       dev_ok = ctrl[4:0] == DEV_EXTENDED;
	wire logic       win    = req_in.addr == ADDR_WINDOW && (req_in.rd || req_in.wr);
	wire logic [1:0] fn     = ctrl[15:14];
	default clocking @(posedge clock_in); endclocking
	default disable iff (rst_in);
	// ====================
	// assertions
	read_answer_a: assert property (req_in.rd |=> rd_valid_out) else $error("read not answered");
	stray_valid_a: assert property (!req_in.rd |=> !rd_valid_out) else $error("stray read valid");
	addr_load_a: assert property (win && dev_ok && fn == 2'h0 && req_in.wr |=> pointer_out == $past(req_in.wdata))
		else $error("pointer not loaded");
	plain_data_a: assert property (win && dev_ok && fn == 2'h1 |=> $stable(pointer_out))
		else $error("pointer moved");
	post_inc_a: assert property (win && dev_ok && fn == 2'h2 |=> pointer_out == $past(pointer_out) + 16'h0001)
		else $error("pointer not bumped");
	write_inc_a: assert property (win && dev_ok && fn == 2'h3 |=>
		pointer_out == $past(pointer_out) + {15'h0000, $past(req_in.wr)}) else $error("write bump wrong");
	dev_gate_a: assert property (win && !dev_ok |=> $stable(pointer_out)) else $error("gated pointer moved");
	gate_read_a: assert property (win && !dev_ok && req_in.rd |=> rd_data_out == 16'h0000)
		else $error("gated read not zero");
	ctrl_rsvd_a: assert property (req_in.rd && req_in.addr == ADDR_EXT_CTRL |=> rd_data_out[13:5] == 9'h000)
		else $error("reserved bits set");
	drop_or_a: assert property (!$past(rst_in) |-> link_drop_out == |$past(drop_in.trigger & drop_in.enable))
		else $error("link drop wrong");
	cover property (win && dev_ok && fn == 2'h2 && req_in.rd);
	cover property (link_drop_out);
	cover property (pointer_out == 16'hffff ##1 pointer_out == 16'h0000);
endmodule // xra_top_monitor

// [xra_mgmt.sv]
// management controller model issuing one register request per call
`timescale 1ns/1ps
module xra_mgmt (
	input  wire logic         clock_in,
	input  wire logic [15:0]  rd_data_in,
	output xra_pkg::xra_req_t req_out
);
	import xra_pkg::*;
	initial req_out = '0;
	// ====================
	// request held from one falling edge to the next, so exactly one rising edge takes it
	task automatic access(input logic w, input logic [4:0] a, input logic [15:0] d, output logic [15:0] q);
		@(negedge clock_in);
		req_out = '{addr: a, rd: !w, wr: w, wdata: d};
		@(negedge clock_in);
		q = rd_data_in;
		// released lines show the inverse, never a stale copy that could hide a late sample
		req_out = '{addr: ~a, rd: 1'b0, wr: 1'b0, wdata: ~d};
	endtask
endmodule // xra_mgmt

// [xra_top_test.sv]
// self-checking bench for the extended register access bank
`timescale 1ns/1ps
module xra_top_test;
	import xra_pkg::*;
	typedef struct packed {logic w; logic [4:0] a; logic [15:0] d; logic [15:0] p;} xra_row_t;
	logic        clock_in = 1'b0;
	logic        rst_in   = 1'b1;
	xra_req_t    req;
	xra_drop_t   drop     = '0;
	logic        rx_err   = 1'b0;
	logic        x_en     = 1'b0;
	logic        x_force  = 1'b0;
	logic        x_swap   = 1'b0;
	logic [15:0] rd_data, ptr, q;
	logic        rd_valid, link_drop;
	int          errors   = 0;
	int          n_checks = 0;
	logic [3:0]  xo [4]   = '{4'h9, 4'h7, 4'h4, 4'h2};
	// ====================
	// window walk: write or read, then register address, then data or expected read, then expected pointer
	xra_row_t rows [22] = '{
		'{1'b1, 5'h0d, 16'h001f, 16'h0000}, '{1'b1, 5'h0e, 16'h0020, 16'h0020},
		'{1'b1, 5'h0d, 16'h401f, 16'h0020}, '{1'b1, 5'h0e, 16'h1234, 16'h0020},
		'{1'b0, 5'h0e, 16'h1234, 16'h0020}, '{1'b1, 5'h0d, 16'h801f, 16'h0020},
		'{1'b0, 5'h0e, 16'h1234, 16'h0021}, '{1'b1, 5'h0e, 16'h5678, 16'h0022},
		'{1'b1, 5'h0d, 16'h001f, 16'h0022}, '{1'b0, 5'h0e, 16'h0022, 16'h0022},
		'{1'b1, 5'h0e, 16'h0021, 16'h0021}, '{1'b1, 5'h0d, 16'hc01f, 16'h0021},
		'{1'b0, 5'h0e, 16'h5678, 16'h0021}, '{1'b1, 5'h0e, 16'h9abc, 16'h0022},
		'{1'b1, 5'h0d, 16'hffff, 16'h0022}, '{1'b0, 5'h0d, 16'hc01f, 16'h0022},
		'{1'b1, 5'h0d, 16'h401e, 16'h0022}, '{1'b1, 5'h0e, 16'h0033, 16'h0022},
		'{1'b0, 5'h0e, 16'h0000, 16'h0022}, '{1'b1, 5'h0d, 16'h401f, 16'h0022},
		'{1'b0, 5'h0e, 16'h0000, 16'h0022}, '{1'b0, 5'h03, 16'h0000, 16'h0022}};
	always #20 clock_in = ~clock_in;
	xra_top i_xra_top (.clock_in(clock_in), .rst_in(rst_in), .req_in(req), .drop_in(drop), .rx_error_in(rx_err),
		.auto_crossover_enable_in(x_en), .forced_crossover_in(x_force), .swap_algorithm_in(x_swap),
		.rd_data_out(rd_data), .rd_valid_out(rd_valid), .link_drop_out(link_drop), .pointer_out(ptr));
	xra_mgmt i_xra_mgmt (.clock_in(clock_in), .rd_data_in(rd_data), .req_out(req));
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] %0t ns: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_sim();
		if (errors == 0 && n_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic op(input logic w, input logic [4:0] a, input logic [15:0] d);
		i_xra_mgmt.access(w, a, d, q);
	endtask
	initial begin
		#80000;
		errors++;
		end_sim();
	end
	initial begin
		repeat (20) @(negedge clock_in);
		rst_in = 1'b0;
		foreach (rows[i]) begin
			op(rows[i].w, rows[i].a, rows[i].d);
			if (!rows[i].w) check(q, rows[i].d);
			check({15'h0000, rd_valid}, {15'h0000, !rows[i].w});
			check(ptr, rows[i].p);
		end
		// ====================
		// pointer wrap: an address outside the extended range reads zero
		op(1'b1, ADDR_EXT_CTRL, 16'h001f);
		op(1'b1, ADDR_WINDOW, 16'hffff);
		op(1'b1, ADDR_EXT_CTRL, 16'h801f);
		op(1'b0, ADDR_WINDOW, 16'h0000);
		check(q, 16'h0000);
		check(ptr, 16'h0000);
		// each cause alone, then every trigger with its enable off
		for (int i = 0; i < CAUSE_W; i++) begin
			@(negedge clock_in);
			drop = '{trigger: 5'h01 << i, enable: 5'h01 << i};
			@(negedge clock_in);
			drop = '{trigger: 5'h1f, enable: 5'h00};
			check({15'h0000, link_drop}, 16'h0001);
			@(negedge clock_in);
			check({15'h0000, link_drop}, 16'h0000);
			drop = '0;
			op(1'b0, ADDR_LINK_DROP, 16'h0000);
			check(q, 16'h0010 << i);
			op(1'b0, ADDR_LINK_DROP, 16'h0000);
			check(q, 16'h0000);
		end
		// a drop that lands in the clearing read cycle must survive it
		drop = '{trigger: 5'h01, enable: 5'h01};
		op(1'b0, ADDR_LINK_DROP, 16'h0000);
		drop = '0;
		check(q, 16'h0010);
		op(1'b0, ADDR_LINK_DROP, 16'h0000);
		check(q, 16'h0010);
		op(1'b0, ADDR_LINK_DROP, 16'h0000);
		check(q, 16'h0000);
		foreach (xo[i]) begin
			{x_force, x_en, x_swap} = xo[i][3:1];
			@(negedge clock_in);
			op(1'b0, ADDR_SUMMARY, 16'h0000);
			check({15'h0000, q[SUM_XOVER_BIT]}, {15'h0000, xo[i][0]});
		end
		rx_err = 1'b1;
		@(negedge clock_in);
		rx_err = 1'b0;
		op(1'b0, ADDR_SUMMARY, 16'h0000);
		check({15'h0000, q[SUM_RXERR_BIT]}, 16'h0001);
		op(1'b0, ADDR_RX_ERR_COUNT, 16'h0000);
		op(1'b0, ADDR_SUMMARY, 16'h0000);
		check({15'h0000, q[SUM_RXERR_BIT]}, 16'h0000);
		// second reset in mid-run, with a pointer that reset must clear
		op(1'b1, ADDR_EXT_CTRL, 16'h001f);
		op(1'b1, ADDR_WINDOW, 16'h0045);
		check(ptr, 16'h0045);
		rst_in = 1'b1;
		@(negedge clock_in);
		rst_in = 1'b0;
		check(ptr, 16'h0000);
		op(1'b0, ADDR_EXT_CTRL, 16'h0000);
		check(q, 16'h0000);
		end_sim();
	end
endmodule // xra_top_test
bind xra_top xra_top_monitor i_xra_top_monitor (.clock_in(clock_in), .rst_in(rst_in), .req_in(req_in),
	.drop_in(drop_in), .rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out), .link_drop_out(link_drop_out),
	.pointer_out(pointer_out));
